/* File: rtl/ffmd_consts.vh */
// Constants for the freefall/motion event detector.
// Assumes a register access port that gives byte offsets and one-cycle strobes.
// What this block does
// [R1] Combine bit clear: all enabled axes low (AND); set: any enabled axis high (OR).
// [R2] All three axis enables zero makes the detector inactive.
// [R3] Low means magnitude at or below threshold; high means strictly above.
// [R4] Axis enable set lets that axis raise flags; clear disables that axis.
// [R5] Event active asserts only when the debounce counter reaches the count.
// [R6] Unlatched, counter mode zero: active clears only once the counter reaches zero.
// [R7] Unlatched, counter mode one: active clears at once, counter restarts from zero.
// [R8] Unlatched, reading source clears no flag and leaves the counter alone.
// [R9] Latched, active holds until source read; read clears flags and counter.
// [R10] Latched, axis flags freeze while active is set, until source read.
// [R11] Axis flags show instantaneous undebounced high status; latched only while active.
// [R12] Config: latch bit 7, combine bit 6, Z/Y/X enables bits 5..3, reset zero.
// [R13] Source: active bit 7, bit 6 zero, Z/Y/X high and sign in bits 5..0.
// [R14] Axis high and sign flags read zero while that axis enable is clear.
// [R15] Sign flag is zero for positive, one for negative acceleration.
// [R16] Debounce counter saturates at the programmed count.
// [R17] Counter mode zero decrements by one per sample while condition false.
// [R18] Counter increments by one per sample while the condition is true.
`ifndef FFMD_CONSTS_VH
`define FFMD_CONSTS_VH
`define FFMD_OFS_CONFIG 8'h15
`define FFMD_OFS_SOURCE 8'h16
`define FFMD_OFS_THRESH 8'h17
`define FFMD_OFS_COUNT 8'h18
`define FFMD_BIT_LATCH 7
`define FFMD_BIT_OR 6
`define FFMD_BIT_ZEN 5
`define FFMD_BIT_YEN 4
`define FFMD_BIT_XEN 3
`define FFMD_BIT_ACTIVE 7
`define FFMD_BIT_CMODE 7
`define FFMD_RST_CONFIG 8'h00
`define FFMD_RST_THRESH 8'h00
`define FFMD_RST_COUNT 8'h00
`define FFMD_ACC_W 14
`endif

/* File: rtl/ffmd_axis.v */
// One axis comparator: magnitude against the threshold, and sign.
// Assumes a two's complement sample whose top 7 magnitude bits align with the threshold.
`timescale 1ns/1ps
`include "ffmd_consts.vh"
module ffmd_axis (
	input wire [`FFMD_ACC_W-1:0] sample,
	input wire [6:0] threshold,
	output wire is_high,
	output wire is_low,
	output wire is_neg
);
	wire [`FFMD_ACC_W-1:0] mag;
	wire [7:0] mag_top;
	// Magnitude; most negative value saturates to full scale
	assign mag = sample[`FFMD_ACC_W-1] ? (~sample + 14'h0001) : sample;
	assign mag_top = (sample == 14'h2000) ? 8'hFF : {1'b0, mag[`FFMD_ACC_W-2:`FFMD_ACC_W-8]};
	assign is_high = mag_top > {1'b0, threshold}; // R3
	assign is_low = ~is_high; // R3
	assign is_neg = sample[`FFMD_ACC_W-1]; // R15
endmodule // ffmd_axis

/* File: rtl/ffmd_top.v */
// Freefall/motion detector with its four registers on the device register port.
// Assumes sample_valid pulses once per output sample; reads and writes are one-cycle strobes.
`timescale 1ns/1ps
`include "ffmd_consts.vh"
module ffmd_top (
	input wire sys_clk,
	input wire reset,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire sample_valid,
	input wire [`FFMD_ACC_W-1:0] accel_x,
	input wire [`FFMD_ACC_W-1:0] accel_y,
	input wire [`FFMD_ACC_W-1:0] accel_z,
	output wire event_active
);
	reg [7:0] config_q;
	reg [7:0] thresh_q;
	reg [7:0] count_q;
	reg [7:0] dbc_q;
	reg [7:0] dbc_d;
	reg active_q;
	reg active_d;
	reg [5:0] flags_q;
	reg [5:0] flags_d;
	wire latch_on_event;
	wire combine_or_mode;
	wire counter_mode;
	wire [2:0] axis_en;
	wire [2:0] hi;
	wire [2:0] lo;
	wire [2:0] neg;
	wire any_en;
	wire cond;
	wire src_read;
	wire [5:0] live_flags;
	wire any_hi;
	wire all_lo;
	wire wr_config;
	wire wr_thresh;
	wire wr_count;
	wire [5:0] flag_mask;
	wire [7:0] source_word;

	// Register write decode; writes to the source or unmapped offsets fall through
	assign wr_config = reg_wr && (reg_addr == `FFMD_OFS_CONFIG);
	assign wr_thresh = reg_wr && (reg_addr == `FFMD_OFS_THRESH);
	assign wr_count = reg_wr && (reg_addr == `FFMD_OFS_COUNT);

	// Per-axis mask, so a disabled axis always reads zero even if frozen set
	assign flag_mask = {axis_en[2], axis_en[2], axis_en[1], axis_en[1], axis_en[0], axis_en[0]}; // R14

	// Source word as seen by the host, bit 6 tied low
	assign source_word = {active_q, 1'b0, flags_q & flag_mask}; // R13

	assign latch_on_event = config_q[`FFMD_BIT_LATCH];
	assign combine_or_mode = config_q[`FFMD_BIT_OR];
	assign counter_mode = thresh_q[`FFMD_BIT_CMODE];
	assign axis_en = {config_q[`FFMD_BIT_ZEN], config_q[`FFMD_BIT_YEN], config_q[`FFMD_BIT_XEN]};
	assign src_read = reg_rd && (reg_addr == `FFMD_OFS_SOURCE);
	assign event_active = active_q;

	// Comparators, index 0 = X, 1 = Y, 2 = Z
	// Comparators are combinational, so flags follow the inputs between samples
	ffmd_axis u_ax_x (
		.sample(accel_x),
		.threshold(thresh_q[6:0]),
		.is_high(hi[0]),
		.is_low(lo[0]),
		.is_neg(neg[0])
	);

	ffmd_axis u_ax_y (
		.sample(accel_y),
		.threshold(thresh_q[6:0]),
		.is_high(hi[1]),
		.is_low(lo[1]),
		.is_neg(neg[1])
	);

	ffmd_axis u_ax_z (
		.sample(accel_z),
		.threshold(thresh_q[6:0]),
		.is_high(hi[2]),
		.is_low(lo[2]),
		.is_neg(neg[2])
	);

	// Combined condition; disabled axes drop out of both AND and OR
	assign any_en = |axis_en; // R2

	// Motion: any enabled axis above threshold
	assign any_hi = |(hi & axis_en); // R1 R4

	// Freefall: every enabled axis at or below threshold
	assign all_lo = &(lo | ~axis_en); // R1 R4

	// No enabled axis means no condition, in either combine mode
	assign cond = any_en && (combine_or_mode ? any_hi : all_lo); // R1 R2

	// Raw axis flags, zero for disabled axes, sign only with a high event
	assign live_flags = {hi[2] & axis_en[2], hi[2] & neg[2] & axis_en[2], // R11 R14 R15
		hi[1] & axis_en[1], hi[1] & neg[1] & axis_en[1],
		hi[0] & axis_en[0], hi[0] & neg[0] & axis_en[0]};

	// Debounce counter and active flag, stepped once per sample
	always @* begin
		dbc_d = dbc_q;
		active_d = active_q;
		if (sample_valid) begin
			if (cond) begin
				if (dbc_q < count_q) // R16
					dbc_d = dbc_q + 8'h01; // R18
				else
					dbc_d = count_q; // R16
			end else if (counter_mode) begin
				dbc_d = 8'h00; // R7
			end else if (dbc_q != 8'h00) begin
				dbc_d = dbc_q - 8'h01; // R17 R6
			end
			// Latched: stays set; otherwise follows the counter
			if (latch_on_event)
				active_d = active_q | (cond && (dbc_d >= count_q)); // R5 R9
			else if (cond && (dbc_d >= count_q))
				active_d = 1'b1; // R5
			else if (counter_mode ? !cond : (dbc_d == 8'h00))
				active_d = 1'b0; // R6 R7
		end
		// Source read clears only in latched mode; a same-cycle sample is lost to the read
		if (src_read && latch_on_event) begin
			dbc_d = 8'h00; // R9
			active_d = 1'b0; // R9
		end
	end

	// Axis flags live, or frozen while latched and active
	always @* begin
		flags_d = flags_q;
		if (!(latch_on_event && active_q)) // R10
			flags_d = live_flags; // R11
		if (src_read && latch_on_event && active_q)
			flags_d = 6'h00; // R9 R10
		if (src_read && !latch_on_event)
			flags_d = live_flags; // R8
	end

	// Detector state; reset clears the counter so no stale event survives
	always @(posedge sys_clk) begin
		if (reset) begin
			dbc_q <= 8'h00;
			active_q <= 1'b0;
			flags_q <= 6'h00;
		end else begin
			dbc_q <= dbc_d;
			active_q <= active_d;
			flags_q <= flags_d;
		end
	end

	// Config register; the unused low bits always store zero
	always @(posedge sys_clk) begin
		if (reset) begin
			config_q <= `FFMD_RST_CONFIG;
		end else if (wr_config) begin
			config_q <= {reg_wdata[7:3], 3'b000}; // R12
		end
	end

	// Threshold and counter mode share one byte
	// Changing it mid-event takes effect on the next sample, counter untouched
	always @(posedge sys_clk) begin
		if (reset) begin
			thresh_q <= `FFMD_RST_THRESH;
		end else if (wr_thresh) begin
			thresh_q <= reg_wdata;
		end
	end

	// Debounce count; lowering it below the running counter saturates at the next sample with the condition true
	always @(posedge sys_clk) begin
		if (reset) begin
			count_q <= `FFMD_RST_COUNT;
		end else if (wr_count) begin
			count_q <= reg_wdata;
		end
	end

	// Read data registered; source shows the value before any clear
	always @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`FFMD_OFS_CONFIG: reg_rdata <= config_q; // R12
				`FFMD_OFS_SOURCE: reg_rdata <= source_word; // R13 R14
				`FFMD_OFS_THRESH: reg_rdata <= thresh_q;
				`FFMD_OFS_COUNT: reg_rdata <= count_q;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule // ffmd_top

/* File: test/ffmd_chk_sva.sv */
// Port checker for the freefall/motion detector.
// Assumes one-cycle host strobes and one clock domain.
`timescale 1ns/1ps
module ffmd_chk (
	input wire sys_clk,
	input wire reset,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire sample_valid,
	input wire event_active
);
	// Single domain, reset masks all
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_unmap; reg_rd && (reg_addr < 8'h15 || reg_addr > 8'h18) |=> !reg_rdata; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_hold; !reset && !reg_rd |=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_top; reg_rd && reg_addr == 8'h16 |=> reg_rdata[7:6] == {$past(event_active), 1'b0}; endproperty
	a_top: assert property (p_top) else $error("source top bits wrong");
	property p_cfglo; reg_rd && reg_addr == 8'h15 |=> reg_rdata[2:0] == 3'h0; endproperty
	a_cfglo: assert property (p_cfglo) else $error("config low bits set");
	property p_sign; reg_rd && reg_addr == 8'h16 |=> !(reg_rdata[4:0] & ~reg_rdata[5:1] & 5'h15); endproperty
	a_sign: assert property (p_sign) else $error("sign without high");
	property p_rise; $rose(event_active) |-> $past(sample_valid); endproperty
	a_rise: assert property (p_rise) else $error("active rose off sample");
	property p_fall; $fell(event_active) |-> $past(sample_valid || reg_rd || reset); endproperty
	a_fall: assert property (p_fall) else $error("active fell without cause");
	property p_cfgrb; reg_rd && reg_addr == 8'h15 && $past(reg_wr && reg_addr == 8'h15)
		|=> reg_rdata[7:3] == $past(reg_wdata[7:3], 2); endproperty
	a_cfgrb: assert property (p_cfgrb) else $error("config readback wrong");
	c_rise: cover property ($rose(event_active));
	c_fall: cover property ($fell(event_active));
	c_src: cover property (reg_rd && reg_addr == 8'h16 && event_active);
endmodule // ffmd_chk
bind ffmd_top ffmd_chk ffmd_chk_inst (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sample_valid(sample_valid), .event_active(event_active));

/* File: test/ffmd_host.sv */
// Host model driving the device register port.
// Assumes its tasks are entered at a rising edge.
`timescale 1ns/1ps
module ffmd_host (
	input wire sys_clk,
	output reg [7:0] reg_addr = 8'h00,
	output reg reg_wr = 1'b0,
	output reg [7:0] reg_wdata = 8'h00,
	output reg reg_rd = 1'b0,
	input wire [7:0] reg_rdata
);
	// Write strobe; data scrambled after so stale values never pass
	task wr(input [7:0] a, input [7:0] d); begin
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	end endtask
	// Read strobe; answer lands one edge after it is taken
	task rd(input [7:0] a, output [7:0] d); begin
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		d = reg_rdata;
	end endtask
endmodule // ffmd_host

/* File: test/ffmd_top_tb.sv */
// Self-checking bench for ffmd_top with a reference model.
// Assumes the host model owns the register port.
`timescale 1ns/1ps
`include "ffmd_consts.vh"
module ffmd_top_tb;
	reg sys_clk = 1'b0;
	reg reset = 1'b1;
	reg sample_valid = 1'b0;
	reg [`FFMD_ACC_W-1:0] accel_x = 14'h0000, accel_y = 14'h0000, accel_z = 14'h0000;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire reg_wr, reg_rd, event_active;
	reg [7:0] cfg, dat;
	reg [6:0] ths;
	reg md, ea;
	reg [5:0] frz, live;
	integer cnt, dc, r, k, fail_count = 0, comparisons = 0;
	ffmd_top ffmd_top_inst (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z), .event_active(event_active));
	ffmd_host ffmd_host_inst (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	task chk(input [7:0] s, input [7:0] e); begin
		comparisons = comparisons + 1;
		if (s !== e) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	end endtask
	task print_verdict; begin
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	end endtask
	// One sample near threshold; shared offset makes all-low and all-high likely
	task smp; integer i, m, d; reg [2:0] hi, ng, en; reg c; begin
		en = cfg[5:3];
		d = $urandom % 8;
		for (i = 0; i < 3; i = i + 1) begin
			m = ths + d + $urandom % 3 - 5;
			ng[i] = $urandom % 2;
			hi[i] = m > ths;
			live[2*i+1] = en[i] & hi[i];
			live[2*i] = en[i] & hi[i] & ng[i];
			if (i == 0) accel_x <= ng[i] ? -(m << 6) : m << 6;
			if (i == 1) accel_y <= ng[i] ? -(m << 6) : m << 6;
			if (i == 2) accel_z <= ng[i] ? -(m << 6) : m << 6;
		end
		c = (en == 3'h0) ? 1'b0 : cfg[6] ? |(hi & en) : &(~hi | ~en);
		sample_valid <= 1'b1;
		@(posedge sys_clk);
		sample_valid <= 1'b0;
		if (c) begin
			cnt = (cnt < dc) ? cnt + 1 : dc;
			if (cnt >= dc && !ea) frz = live;
			if (cnt >= dc) ea = 1'b1;
		end else begin
			cnt = (md || cnt == 0) ? 0 : cnt - 1;
			if (cnt == 0 && !cfg[7]) ea = 1'b0;
		end
	end endtask
	// Every latch, combine and counter mode twice
	initial begin
		k = $urandom(35);
		for (r = 0; r < 16; r = r + 1) begin
			reset <= 1'b1;
			repeat (5) @(posedge sys_clk);
			reset <= 1'b0;
			cnt = 0;
			ea = 1'b0;
			@(posedge sys_clk);
			ffmd_host_inst.rd(`FFMD_OFS_CONFIG, dat);
			chk(dat, `FFMD_RST_CONFIG);
			ffmd_host_inst.rd(8'h19 + $urandom % 200, dat);
			chk(dat, 8'h00);
			cfg = {r[1:0], 6'h00} | ($urandom & 8'h3F);
			ffmd_host_inst.wr(`FFMD_OFS_CONFIG, cfg);
			ffmd_host_inst.rd(`FFMD_OFS_CONFIG, dat);
			chk(dat, cfg & 8'hF8);
			ffmd_host_inst.wr(`FFMD_OFS_SOURCE, 8'hFF);
			md = r[2];
			ths = 8 + $urandom % 112;
			dc = $urandom % 4;
			@(posedge sys_clk);
			ffmd_host_inst.wr(`FFMD_OFS_THRESH, {md, ths});
			@(posedge sys_clk);
			ffmd_host_inst.wr(`FFMD_OFS_COUNT, dc[7:0]);
			ffmd_host_inst.rd(`FFMD_OFS_THRESH, dat);
			chk(dat, {md, ths});
			ffmd_host_inst.rd(`FFMD_OFS_COUNT, dat);
			chk(dat, dc[7:0]);
			for (k = 0; k < 30; k = k + 1) begin
				smp;
				@(posedge sys_clk);
				chk(event_active, ea);
				if ($urandom % 2) begin
					ffmd_host_inst.rd(`FFMD_OFS_SOURCE, dat);
					chk(dat, {ea, 1'b0, (ea && cfg[7]) ? frz : live});
					if (cfg[7]) {ea, cnt} = 0;
				end
			end
			$display("round %0d done", r);
		end
		print_verdict;
	end
	// Watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count = fail_count + 1;
		print_verdict;
	end
endmodule // ffmd_top_tb
